// ---- logic/dio_port.v ----
// Four-bit digital I/O port on the board's I/O space.
// Assumes synchronous bus strobes in the i_clk domain, a static base select,
// and asynchronous input pins that are synchronised here.
`timescale 1ns/10ps
`default_nettype none
`include "dio_consts.vh"

////////////////////////////////////////////////////////////////////////////
module dio_port
#(
  parameter CH = `DIO_CH_COUNT
)
(
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst,
  // Configuration
  input  wire        i_alt_base,
  // Board bus, one-cycle strobes
  input  wire [15:0] i_io_addr,
  input  wire        i_io_rd,
  input  wire        i_io_wr,
  input  wire        i_mem_rd,
  input  wire        i_mem_wr,
  input  wire [7:0]  i_io_wdata,
  output wire [7:0]  o_io_rdata,
  output wire        o_io_rvalid,
  // Input pins
  input  wire        i_input_line_0,
  input  wire        i_input_line_1,
  input  wire        i_input_line_2,
  input  wire        i_input_line_3,
  // Output pins
  output wire        o_output_line_0,
  output wire        o_output_line_1,
  output wire        o_output_line_2,
  output wire        o_output_line_3
);

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  // Used by both read and write decode
  function addr_hit;
    input [15:0] addr;
    input        alt;
    begin
      addr_hit = alt ? (addr == `DIO_BASE_ALT)
                     : (addr == `DIO_BASE_DEFAULT);
    end
  endfunction

  wire        rd_hit;
  wire        wr_hit;
  wire [CH-1:0] pins_async;
  wire [CH-1:0] pins_sync;

  // Memory strobes are deliberately ignored
  assign rd_hit = i_io_rd && addr_hit(i_io_addr, i_alt_base);
  assign wr_hit = i_io_wr && addr_hit(i_io_addr, i_alt_base);

  ////////////////////////////////////////////////////////////////////////
  // Input path

  assign pins_async = {i_input_line_3, i_input_line_2,
                       i_input_line_1, i_input_line_0};

  dio_sync #(
    .WIDTH (CH)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (pins_async),
    .o_sync  (pins_sync)
  );

  reg  [7:0] rdata_reg;
  reg        rvalid_reg;

  // Read data is registered; unused upper bits read as zero
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= rd_hit;
      if (rd_hit)
        rdata_reg <= {{(8-CH){1'b0}}, pins_sync};
      else
        rdata_reg <= 8'h00;
    end
  end

  assign o_io_rdata  = rdata_reg;
  assign o_io_rvalid = rvalid_reg;

  ////////////////////////////////////////////////////////////////////////
  // Output latch

  reg  [CH-1:0] latch_reg;

  // Write-only: no path from latch_reg to the read data
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      latch_reg <= `DIO_LATCH_RESET;
    else if (wr_hit)
      latch_reg <= i_io_wdata[CH-1:0];
  end

  assign o_output_line_0 = latch_reg[0];
  assign o_output_line_1 = latch_reg[1];
  assign o_output_line_2 = latch_reg[2];
  assign o_output_line_3 = latch_reg[3];

endmodule // dio_port

`default_nettype wire

// ---- logic/dio_consts.vh ----
// Address map, field positions and reset values of the four-bit I/O port.
// Assumes 16-bit I/O addresses from the board bus; header only.
`ifndef DIO_CONSTS_VH
`define DIO_CONSTS_VH

// I/O base addresses, shared by read and write
`define DIO_BASE_DEFAULT   16'h0340
`define DIO_BASE_ALT       16'h0240

// Field layout
`define DIO_CH_COUNT       4
`define DIO_FIELD_LSB      0
`define DIO_FIELD_MSB      3
`define DIO_BUS_WIDTH      8

// Reset values
`define DIO_LATCH_RESET    4'h0

// Synchroniser depth
`define DIO_SYNC_STAGES    2

`endif

// ---- logic/dio_sync.v ----
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes each bit is an independent slow level such as a switch input.
`timescale 1ns/10ps
`default_nettype none

module dio_sync
#(
  parameter WIDTH = 4
)
(
  // Clock and reset
  input  wire             i_clk,
  input  wire             i_rst,
  // Levels
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // First stage feeds only the second stage
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule // dio_sync

`default_nettype wire

// ---- test/dio_switches.sv ----
// Switch model; the bench sets states at clock edges.
`timescale 1ns/10ps
`default_nettype none
module dio_switches(
  input  wire logic       i_clk,
  input  wire logic [3:0] i_set,
  output var  logic [3:0] o_line);
  always @(posedge i_clk) o_line <= i_set;
endmodule // dio_switches
`default_nettype wire

// ---- test/dio_port_monitor.sv ----
// Port checker; one clock, one-cycle strobes.
`timescale 1ns/10ps
`default_nettype none
module dio_port_monitor(
  input wire logic i_clk, i_rst, i_alt_base, i_io_rd, i_io_wr,
  input wire logic o_io_rvalid, o_output_line_0, o_output_line_1,
  input wire logic o_output_line_2, o_output_line_3,
  input wire logic [15:0] i_io_addr,
  input wire logic [7:0] i_io_wdata, o_io_rdata);
  wire h = i_io_addr == (i_alt_base ? 16'h0240 : 16'h0340);
  wire r = i_io_rd && h;
  wire w = i_io_wr && h;
  wire [3:0] q = {o_output_line_3, o_output_line_2, o_output_line_1,
    o_output_line_0};
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence wr_s; w; endsequence
  rd_ack_a: assert property (r |=> o_io_rvalid)
    else $error("no ack");
  rd_miss_a: assert property (!r |=> !o_io_rvalid)
    else $error("stray ack");
  wr_load_a: assert property (wr_s |=> q == $past(i_io_wdata[3:0]))
    else $error("bad load");
  out_hold_a: assert property (!w |=> $stable(q))
    else $error("lines moved");
  rd_top_a: assert property (o_io_rdata[7:4] == 4'h0)
    else $error("top bits");
  rd_idle_a: assert property (!o_io_rvalid |-> !o_io_rdata)
    else $error("idle data");
  rst_clr_a: assert property ($fell(i_rst) |-> q == 4'h0)
    else $error("not clear");
  both_act_a: assert property (r ##0 wr_s |=> o_io_rvalid)
    else $error("read lost");
endmodule // dio_port_monitor
bind dio_port dio_port_monitor mon (.*);
`default_nettype wire

// ---- test/dio_port_tb.sv ----
// Port bench with random switch and latch values.
`timescale 1ns/10ps
`default_nettype none
module dio_port_tb;
  logic i_clk = 0, i_rst = 1, i_alt_base = 0, i_io_rd = 0, i_io_wr = 0;
  logic i_mem_rd = 0, i_mem_wr = 0, a;
  logic [15:0] i_io_addr = 0;
  logic [7:0] i_io_wdata = 0, o_io_rdata;
  logic [3:0] sw = 0, l;
  wire o_io_rvalid, o_output_line_0, o_output_line_1, o_output_line_2,
    o_output_line_3, i_input_line_0, i_input_line_1, i_input_line_2,
    i_input_line_3;
  wire [3:0] q = {o_output_line_3, o_output_line_2, o_output_line_1,
    o_output_line_0};
  int errors = 0, n_checks = 0, cyc = 0, i;
  dio_port dut (.*);
  dio_switches sws (.i_clk, .i_set(sw), .o_line({i_input_line_3,
    i_input_line_2, i_input_line_1, i_input_line_0}));
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk)
    if (++cyc > 2000)
      stop_test;
  function [15:0] base(input b);
    base = b ? 16'h0240 : 16'h0340;
  endfunction
  task chk(input [7:0] g, e);
    n_checks++;
    if (g !== e)
      $display("mismatch %0t %h %h", $time, g, e);
    errors += g !== e;
  endtask
  task acc(input r, w, m, b, input [7:0] d);
    @(posedge i_clk);
    {i_io_rd, i_io_wr, i_mem_rd, i_mem_wr} <= {r, w, m, m};
    {i_io_addr, i_io_wdata} <= {base(b), d};
    @(posedge i_clk);
    {i_io_rd, i_io_wr, i_mem_rd, i_mem_wr} <= 4'h0;
    #1;
  endtask
  task stop_test;
    // A hang counts as one mismatch
    errors += cyc > 2000;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    void'($urandom(11166));
    repeat (3) @(posedge i_clk);
    i_rst <= 0;
    #1 chk(q, 0);
    for (i = 0; i < 40; i++)
    begin
      a = i[0];
      @(posedge i_clk) i_alt_base <= a;
      // Corner: latch all ones against quiet pins, then the reverse
      sw <= (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom);
      l = (i == 0) ? 4'hF : (i == 1) ? 4'h0 : 4'($urandom);
      repeat (3) @(posedge i_clk);
      acc(1, 1, 0, a, {4'hA, l});
      chk(q, l);
      chk(o_io_rdata, sw);
      chk(o_io_rvalid, 1);
      acc(1, 1, 1, !a, ~l);
      chk(q, l);
      chk(o_io_rvalid, 0);
      chk(o_io_rdata, 0);
      $display("test %0d done", i);
    end
    stop_test;
  end
endmodule // dio_port_tb
`default_nettype wire
